// ===== rtl/pin_mux_regs.svh
// Constants for the processor mode and pin function multiplexer.
//------------------------------------------------------------------------------
// Behaviour
// - Mode pin low gives single-chip or expansion mode; high gives microprocessor mode.
// - A low reset input puts the whole block into its reset state.
// - Strobe pin shows data access enable in single-chip, read strobe otherwise.
// - In bus modes, width pin low means 16-bit bus, high means 8-bit.
// - Single-chip port pins each have a direction bit; all are inputs after reset.
// - Bus modes drive address 0-7 on port 0, 8-15 on port 1, 16-19,23 on port 2.
// - Bus modes put write strobe, high byte enable, latch enable, hold ack on port 3.
// - Bus modes use port 4 pins 0,1,2 as hold request, ready, phase-one clock.
// - Only memory expansion mode lets software keep port 4 pin 2 as a port pin.
// - Bus modes let port 9 pins carry address 20-22 or chip selects zero to four.
// - Port 5 pins also serve timers A0-A3, motor waveforms and key interrupts.
// - Port 6 pins also serve timer A4, interrupts zero to two, timers B0-B2.
// - Port 7 pins also serve as converter analog inputs.
// - Port 8 pins also serve serial units, converter outputs and interrupt four.
//------------------------------------------------------------------------------
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

`define PM_NUM_PORTS   12
`define PM_PORT_ADDR_L 0
`define PM_PORT_ADDR_M 1
`define PM_PORT_ADDR_H 2
`define PM_PORT_CTRL   3
`define PM_PORT_HOLD   4
`define PM_PORT_ALT_LO 5
`define PM_PORT_ALT_HI 8
`define PM_PORT_SEL    9
`define PM_PORT_DATA_L 10
`define PM_PORT_DATA_H 11
`define PM_ALT_PORTS   4
`define PM_P9_ADDR_PINS 3
`define PM_P9_ADDR_BASE 20
`define PM_P9_FN_PINS  5
`define PM_ADDR_TOP    23
`define PM_P4_PHI1_BIT 2
`define PM_BYTE_ZERO   8'h00
`define PM_MASK_FULL   8'hFF
`define PM_MASK_P2     8'h8F
`define PM_MASK_P3     8'h0F
`define PM_MASK_P9     8'h3F

`endif

// ===== rtl/pin_mux_pkg.sv
// Types shared by the processor mode and pin function multiplexer.
package pin_mux_pkg;

	typedef enum logic [1:0] {
		MODE_SINGLE_CHIP  = 2'b00,
		MODE_MEM_EXPAND   = 2'b01,
		MODE_MICROPROC    = 2'b10
	} proc_mode_t;

	typedef logic [7:0] port_byte_t;

endpackage : pin_mux_pkg

// ===== rtl/pin_function_mux.sv
// Processor mode selection and per-pin function multiplexing of all I/O ports.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.svh"

module pin_function_mux (
	input  wire logic                   i_ref_clk,                // System clock.
	input  wire logic                   i_rst_b,                  // Reset pin, active low.
	input  wire logic                   i_processor_mode_pin,     // Mode pin level.
	input  wire logic                   i_mem_expand_sel,         // Core asks expansion mode.
	input  wire logic                   i_bus_width_pin,          // Width pin, high is 8-bit.
	input  wire logic                   i_port_wr,                // Core writes a port register.
	input  wire logic                   i_port_dir_sel,           // 1 selects direction register.
	input  wire logic [3:0]             i_port_idx,               // Port number written.
	input  wire logic [7:0]             i_port_wdata,             // Value written.
	input  wire logic [11:0][7:0]       i_pin_in,                 // Pin input levels.
	output logic      [11:0][7:0]       o_pin_out,                // Pin output levels.
	output logic      [11:0][7:0]       o_pin_oe_b,               // Pin drive enable, low drives.
	output logic      [11:0][7:0]       o_pin_sampled,            // Sampled pins for core.
	input  wire logic [3:0][7:0]        i_alt_en,                 // Peripheral owns pin, ports 5-8.
	input  wire logic [3:0][7:0]        i_alt_out,                // Peripheral output level.
	input  wire logic [3:0][7:0]        i_alt_drv,                // Peripheral drives pin.
	input  wire logic [23:0]            i_bus_addr,               // External bus address.
	input  wire logic [15:0]            i_bus_wdata,              // External write data.
	input  wire logic                   i_bus_write_cycle,        // External write in progress.
	input  wire logic                   i_data_access,            // Data bus access state.
	input  wire logic                   i_read_strobe_b,          // Read strobe, active low.
	input  wire logic                   i_write_strobe_b,         // Write strobe, active low.
	input  wire logic                   i_high_byte_enable_b,     // High byte enable, low.
	input  wire logic                   i_addr_latch_enable,      // Address latch enable.
	input  wire logic                   i_hold_acknowledge_out_b, // Hold acknowledge, low.
	input  wire logic                   i_phase_one_clk,          // Phase-one clock level.
	input  wire logic                   i_port_four_pin_two_as_port, // Keep pin as port.
	input  wire logic [4:0]             i_chip_select_outputs_b,  // Chip selects, low.
	input  wire logic [5:0]             i_p9_bus_fn,              // Port 9 pin takes bus role.
	input  wire logic [2:0]             i_p9_addr_sel,            // Pins 0-2 carry address.
	output logic      [1:0]             o_proc_mode,              // Current processor mode.
	output logic                        o_bus_16bit,              // External bus is 16-bit.
	output logic                        o_enable_strobe,          // Strobe output pin.
	output logic                        o_hold_request_b,         // Hold request to core.
	output logic                        o_ready_b,                // Wait-ready to core.
	output logic      [15:0]            o_bus_rdata               // External read data.
);

	//--------------------------------------------------------------------------
	// State
	//--------------------------------------------------------------------------
	pin_mux_pkg::proc_mode_t mode_r;
	pin_mux_pkg::proc_mode_t mode_nxt;
	logic [11:0][7:0]        port_data_r;
	logic [11:0][7:0]        port_dir_r;
	logic [11:0][7:0]        fn_en;
	logic [11:0][7:0]        fn_out;
	logic [11:0][7:0]        fn_drv;
	logic [11:0][7:0]        pin_mask;
	logic                    bus_mode;
	logic                    bus_16bit;

	// Mode pin high forces microprocessor mode; low lets the core choose.
	always_comb begin
		if (i_processor_mode_pin) begin
			mode_nxt = pin_mux_pkg::MODE_MICROPROC;
		end else if (i_mem_expand_sel) begin
			mode_nxt = pin_mux_pkg::MODE_MEM_EXPAND;
		end else begin
			mode_nxt = pin_mux_pkg::MODE_SINGLE_CHIP;
		end
	end

	// Mode register; reset returns the device to single-chip state.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_r <= pin_mux_pkg::MODE_SINGLE_CHIP;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign bus_mode  = (mode_r != pin_mux_pkg::MODE_SINGLE_CHIP);
	// The width pin is trusted to be static, so it is used without filtering.
	assign bus_16bit = bus_mode && !i_bus_width_pin;

	// Port data and direction registers; all pins are inputs after reset.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			port_data_r <= '0;
			port_dir_r  <= '0;
		end else if (i_port_wr && (i_port_idx < 4'(`PM_NUM_PORTS))) begin
			if (i_port_dir_sel) begin
				port_dir_r[i_port_idx] <= i_port_wdata;
			end else begin
				port_data_r[i_port_idx] <= i_port_wdata;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Function assignment per pin
	//--------------------------------------------------------------------------
	// Pins that exist on each port; missing bits are never driven.
	always_comb begin
		pin_mask = {`PM_NUM_PORTS{`PM_MASK_FULL}};
		pin_mask[`PM_PORT_ADDR_H] = `PM_MASK_P2;
		pin_mask[`PM_PORT_CTRL]   = `PM_MASK_P3;
		pin_mask[`PM_PORT_SEL]    = `PM_MASK_P9;
	end

	// Each pin either follows its port registers or a bus or peripheral function.
	always_comb begin
		fn_en  = '0;
		fn_out = '0;
		fn_drv = '0;
		// Peripheral alternates on ports 5 to 8.
		for (int p = 0; p < `PM_ALT_PORTS; p++) begin
			fn_en[`PM_PORT_ALT_LO + p]  = i_alt_en[p];
			fn_out[`PM_PORT_ALT_LO + p] = i_alt_out[p];
			fn_drv[`PM_PORT_ALT_LO + p] = i_alt_drv[p] & i_alt_en[p];
		end
		if (bus_mode) begin
			// Address bytes.
			fn_en[`PM_PORT_ADDR_L]  = `PM_MASK_FULL;
			fn_out[`PM_PORT_ADDR_L] = i_bus_addr[7:0];
			fn_drv[`PM_PORT_ADDR_L] = `PM_MASK_FULL;
			fn_en[`PM_PORT_ADDR_M]  = `PM_MASK_FULL;
			fn_out[`PM_PORT_ADDR_M] = i_bus_addr[15:8];
			fn_drv[`PM_PORT_ADDR_M] = `PM_MASK_FULL;
			fn_en[`PM_PORT_ADDR_H]  = `PM_MASK_P2;
			fn_out[`PM_PORT_ADDR_H] = {i_bus_addr[`PM_ADDR_TOP], 3'b000, i_bus_addr[19:16]};
			fn_drv[`PM_PORT_ADDR_H] = `PM_MASK_P2;
			// Bus control outputs.
			fn_en[`PM_PORT_CTRL]  = `PM_MASK_P3;
			fn_out[`PM_PORT_CTRL] = {4'h0, i_hold_acknowledge_out_b, i_addr_latch_enable,
				i_high_byte_enable_b, i_write_strobe_b};
			fn_drv[`PM_PORT_CTRL] = `PM_MASK_P3;
			// Hold and ready inputs, phase-one clock output.
			fn_en[`PM_PORT_HOLD][1:0] = 2'b11;
			if (!((mode_r == pin_mux_pkg::MODE_MEM_EXPAND) && i_port_four_pin_two_as_port)) begin
				fn_en[`PM_PORT_HOLD][`PM_P4_PHI1_BIT]  = 1'b1;
				fn_out[`PM_PORT_HOLD][`PM_P4_PHI1_BIT] = i_phase_one_clk;
				fn_drv[`PM_PORT_HOLD][`PM_P4_PHI1_BIT] = 1'b1;
			end
			// Port 9 high address bits or chip selects.
			for (int b = 0; b < `PM_P9_FN_PINS; b++) begin
				if (i_p9_bus_fn[b]) begin
					fn_en[`PM_PORT_SEL][b]  = 1'b1;
					fn_drv[`PM_PORT_SEL][b] = 1'b1;
					if ((b < `PM_P9_ADDR_PINS) && i_p9_addr_sel[b % `PM_P9_ADDR_PINS]) begin
						// The modulo keeps the unrolled index inside the address bus.
						fn_out[`PM_PORT_SEL][b] =
							i_bus_addr[`PM_P9_ADDR_BASE + (b % `PM_P9_ADDR_PINS)];
					end else begin
						fn_out[`PM_PORT_SEL][b] = i_chip_select_outputs_b[b];
					end
				end
			end
			// Data bus: low byte always, high byte only on a 16-bit bus.
			fn_en[`PM_PORT_DATA_L] = `PM_MASK_FULL;
			fn_drv[`PM_PORT_DATA_L] = {8{i_bus_write_cycle}};
			if (!bus_16bit && i_bus_addr[0]) begin
				fn_out[`PM_PORT_DATA_L] = i_bus_wdata[15:8];
			end else begin
				fn_out[`PM_PORT_DATA_L] = i_bus_wdata[7:0];
			end
			if (bus_16bit) begin
				fn_en[`PM_PORT_DATA_H]  = `PM_MASK_FULL;
				fn_out[`PM_PORT_DATA_H] = i_bus_wdata[15:8];
				fn_drv[`PM_PORT_DATA_H] = {8{i_bus_write_cycle}};
			end
		end
	end

	//--------------------------------------------------------------------------
	// Pin drivers
	//--------------------------------------------------------------------------
	// An owning function overrides the port data and direction registers.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin_out  <= '0;
			o_pin_oe_b <= '1;
		end else begin
			o_pin_out  <= ((fn_en & fn_out) | (~fn_en & port_data_r)) & pin_mask;
			o_pin_oe_b <= ~(((fn_en & fn_drv) | (~fn_en & port_dir_r)) & pin_mask);
		end
	end

	// Pin levels sampled for the core and its peripherals.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pin_sampled <= '0;
		end else begin
			o_pin_sampled <= i_pin_in & pin_mask;
		end
	end

	//--------------------------------------------------------------------------
	// Bus side signals
	//--------------------------------------------------------------------------
	// Strobe pin, hold request and ready; outside bus modes the strobe shows data access and hold and ready sit idle.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_enable_strobe  <= 1'b1;
			o_hold_request_b <= 1'b1;
			o_ready_b        <= 1'b0;
		end else begin
			o_enable_strobe  <= bus_mode ? i_read_strobe_b : i_data_access;
			o_hold_request_b <= bus_mode ? i_pin_in[`PM_PORT_HOLD][0] : 1'b1;
			o_ready_b        <= bus_mode ? i_pin_in[`PM_PORT_HOLD][1] : 1'b0;
		end
	end

	// Read data gathered from the data pins by bus width and address parity.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bus_rdata <= '0;
		end else if (bus_16bit) begin
			o_bus_rdata <= {i_pin_in[`PM_PORT_DATA_H], i_pin_in[`PM_PORT_DATA_L]};
		end else if (i_bus_addr[0]) begin
			o_bus_rdata <= {i_pin_in[`PM_PORT_DATA_L], `PM_BYTE_ZERO};
		end else begin
			o_bus_rdata <= {`PM_BYTE_ZERO, i_pin_in[`PM_PORT_DATA_L]};
		end
	end

	// Mode and width reported to the core.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_proc_mode <= pin_mux_pkg::MODE_SINGLE_CHIP;
			o_bus_16bit <= 1'b0;
		end else begin
			o_proc_mode <= mode_r;
			o_bus_16bit <= bus_16bit;
		end
	end

endmodule : pin_function_mux
`default_nettype wire

// ===== tb/pin_function_mux_sva.sv
// Port checks for the pin function multiplexer.
`timescale 1ns/1ps
`default_nettype none
module pin_function_mux_sva (
	input wire logic             i_ref_clk,            // Clock.
	input wire logic             i_rst_b,              // Reset.
	input wire logic             i_processor_mode_pin, // Mode pin.
	input wire logic             i_mem_expand_sel,     // Expansion.
	input wire logic             i_bus_width_pin,      // Width pin.
	input wire logic [11:0][7:0] i_pin_in,             // Pin levels.
	input wire logic [11:0][7:0] o_pin_out,            // Pin out.
	input wire logic [11:0][7:0] o_pin_oe_b,           // Pin drive.
	input wire logic [23:0]      i_bus_addr,           // Address.
	input wire logic             i_read_strobe_b,      // Read strobe.
	input wire logic             i_phase_one_clk,      // Phase clock.
	input wire logic [1:0]       o_proc_mode,          // Mode.
	input wire logic             o_bus_16bit,          // Width.
	input wire logic             o_enable_strobe,      // Strobe pin.
	input wire logic             o_hold_request_b      // Hold.
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	// Reset released and mode inputs steady for three edges, so mode and pins have settled.
	sequence bus_s; (i_rst_b && (i_processor_mode_pin || i_mem_expand_sel))[*3]; endsequence
	sequence one_s; (i_rst_b && !i_processor_mode_pin && !i_mem_expand_sel)[*3]; endsequence
	sequence up_s; (i_rst_b && i_processor_mode_pin)[*3]; endsequence
	mode_micro_a: assert property (up_s |-> o_proc_mode == 2'b10)
		else $error("mode not microprocessor");
	mode_single_a: assert property (one_s |-> o_proc_mode == 2'b00)
		else $error("mode not single-chip");
	reset_state_a: assert property (@(posedge i_ref_clk) disable iff (1'b0)
		!i_rst_b |-> &o_pin_oe_b && o_proc_mode == 2'b00) else $error("reset state wrong");
	strobe_bus_a: assert property (bus_s |-> o_enable_strobe == $past(i_read_strobe_b))
		else $error("strobe not read strobe");
	bus_width_a: assert property (bus_s |-> o_bus_16bit == !$past(i_bus_width_pin))
		else $error("bus width wrong");
	addr_pins_a: assert property (bus_s |-> o_pin_out[2:0] ==
		{$past(i_bus_addr[23]), 3'b000, $past(i_bus_addr[19:0])}) else $error("address pins");
	addr_drive_a: assert property (bus_s |-> o_pin_oe_b[2:0] == 24'h70_0000)
		else $error("address drive");
	hold_req_a: assert property (bus_s |-> o_hold_request_b == $past(i_pin_in[4][0])
		&& o_pin_oe_b[4][1:0] == 2'b11) else $error("hold request");
	phase_clk_a: assert property (up_s |-> !o_pin_oe_b[4][2]
		&& o_pin_out[4][2] == $past(i_phase_one_clk)) else $error("phase clock pin");
endmodule : pin_function_mux_sva
bind pin_function_mux pin_function_mux_sva chk_u (.i_ref_clk, .i_rst_b, .i_processor_mode_pin,
	.i_mem_expand_sel, .i_bus_width_pin, .i_pin_in, .o_pin_out, .o_pin_oe_b, .i_bus_addr,
	.i_read_strobe_b, .i_phase_one_clk, .o_proc_mode, .o_bus_16bit, .o_enable_strobe,
	.o_hold_request_b);
`default_nettype wire

// ===== tb/ext_bus_model.sv
// Model of the external memory and board on the pin side.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_model (
	input wire logic             i_ref_clk,  // Clock.
	input wire logic [11:0][7:0] i_pin_out,  // Device pin levels.
	input wire logic [11:0][7:0] i_pin_oe_b, // Device drive, low.
	input wire logic [11:0][7:0] i_ext,      // Board levels.
	input wire logic             i_rd_b,     // Read strobe, low.
	input wire logic             i_hold_b,   // Hold request level.
	input wire logic             i_rdy_b,    // Wait-ready level.
	input wire logic [15:0]      i_word,     // Memory read word.
	output logic     [11:0][7:0] o_pin_in    // Resolved levels.
);
	logic tog_r = 1'b0;
	// Released data lines change every cycle so stale data never passes.
	always_ff @(posedge i_ref_clk) begin
		tog_r <= !tog_r;
	end
	// A pin shows the device level where it drives, else the far side level.
	always_comb begin
		o_pin_in = i_ext;
		o_pin_in[4][1:0] = {i_rdy_b, i_hold_b};
		o_pin_in[11:10] = i_rd_b ? ({16{tog_r}} ^ 16'h5555) : i_word;
		for (int p = 0; p < 12; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (!i_pin_oe_b[p][b]) begin
					o_pin_in[p][b] = i_pin_out[p][b];
				end
			end
		end
	end
endmodule : ext_bus_model
`default_nettype wire

// ===== tb/pin_function_mux_bench.sv
// Self-checking bench for the pin function multiplexer.
`timescale 1ns/1ps
`default_nettype none
module pin_function_mux_bench;
	logic clk = 1'b0, rst_b = 1'b1, mpin = 1'b0, msel = 1'b0, wpin = 1'b0, pwr = 1'b0;
	logic pdir = 1'b0, dacc = 1'b0, rd_b = 1'b1, wr_b = 1'b1, bhe_b = 1'b1, ale = 1'b0;
	logic hold_acknowledge_out_b = 1'b1, phi = 1'b0, keep = 1'b0, mhold_b = 1'b1, b16, strb, hreq_b, rdy_b;
	logic [3:0]       pidx = 4'h0;
	logic [7:0]       pwd = 8'h00;
	logic [4:0]       cs_b = 5'h1F;
	logic [5:0]       p9fn = 6'h00;
	logic [2:0]       p9sel = 3'h0;
	logic [15:0]      word = 16'h1234, rdata;
	logic [23:0]      addr = 24'hAB_CDEF;
	logic [3:0][7:0]  alt_en = '0, alt_out = '0, alt_drv = '0;
	logic [11:0][7:0] ext = {40'h0, 8'h96, 48'h0}, pin_in, pout, poe_b, psam;
	logic [1:0]       mode;
	int               fail_count = 0, tests_run = 0, cyc = 0;
	pin_function_mux dut_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_processor_mode_pin(mpin),
		.i_mem_expand_sel(msel), .i_bus_width_pin(wpin), .i_port_wr(pwr), .i_port_dir_sel(pdir),
		.i_port_idx(pidx), .i_port_wdata(pwd), .i_pin_in(pin_in), .o_pin_out(pout),
		.o_pin_oe_b(poe_b), .o_pin_sampled(psam), .i_alt_en(alt_en), .i_alt_out(alt_out),
		.i_alt_drv(alt_drv), .i_bus_addr(addr), .i_bus_wdata(16'h0000), .i_bus_write_cycle(1'b0),
		.i_data_access(dacc), .i_read_strobe_b(rd_b), .i_write_strobe_b(wr_b),
		.i_high_byte_enable_b(bhe_b), .i_addr_latch_enable(ale), .i_hold_acknowledge_out_b(hold_acknowledge_out_b),
		.i_phase_one_clk(phi), .i_port_four_pin_two_as_port(keep), .i_chip_select_outputs_b(cs_b),
		.i_p9_bus_fn(p9fn), .i_p9_addr_sel(p9sel), .o_proc_mode(mode), .o_bus_16bit(b16),
		.o_enable_strobe(strb), .o_hold_request_b(hreq_b), .o_ready_b(rdy_b), .o_bus_rdata(rdata));
	ext_bus_model far_u (.i_ref_clk(clk), .i_pin_out(pout), .i_pin_oe_b(poe_b), .i_ext(ext),
		.i_rd_b(rd_b), .i_hold_b(mhold_b), .i_rdy_b(1'b1), .i_word(word), .o_pin_in(pin_in));
	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// Writes a port data or direction register with a one-cycle pulse.
	task automatic pw(input logic d, input logic [3:0] i, input logic [7:0] v);
		@(posedge clk);
		pwr <= 1'b1;
		pdir <= d;
		pidx <= i;
		pwd <= v;
		@(posedge clk);
		pwr <= 1'b0;
	endtask : pw
	// Width only changes while reset is held, so it is static in every bus cycle.
	task automatic rst(input logic m, input logic w);
		@(posedge clk);
		rst_b <= 1'b0;
		mpin <= m;
		msel <= 1'b0;
		wpin <= w;
		repeat (4) @(posedge clk);
		#1;
		chk("reset drive", 16'h0001, 16'(&poe_b));
		@(posedge clk);
		rst_b <= 1'b1;
		wt(3);
	endtask : rst
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		forever #4 clk = ~clk;
	end
	// Cuts a hung run short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			wrap_up();
		end
	end
	// Single-chip mode: enable strobe, port registers, a refused index and pin sampling.
	task automatic single_test();
		chk("single strobe", 16'h0000, 16'(strb));
		chk("single ready", 16'h0000, 16'(rdy_b));
		pw(1'b1, 4'h0, 8'hA5);
		pw(1'b0, 4'h0, 8'h3C);
		pw(1'b1, 4'hC, 8'hFF);
		wt(2);
		chk("mode", 16'h0000, 16'(mode));
		chk("p0 drive", 16'h005A, 16'(poe_b[0]));
		chk("p0 out", 16'h003C, 16'(pout[0]));
		chk("p6 in", 16'h0096, 16'(psam[6]));
		$display("single-chip test done");
	endtask : single_test
	// Peripherals take over ports 5 to 8 against the port registers.
	task automatic alt_test();
		@(posedge clk);
		for (int k = 0; k < 4; k++) begin
			alt_en[k] <= 8'hFF;
			alt_out[k] <= 8'h5A ^ 8'(k);
			alt_drv[k] <= 8'h0F;
		end
		wt(2);
		for (int k = 0; k < 4; k++) begin
			chk("alt out", 16'(8'h5A ^ 8'(k)), 16'(pout[k + 5]));
			chk("alt drive", 16'h00F0, 16'(poe_b[k + 5]));
		end
		$display("alternate function test done");
	endtask : alt_test
	// Memory expansion mode on a 16-bit bus with port 4 pin 2 kept as a port.
	task automatic expand_test();
		@(posedge clk);
		alt_en <= '0;
		msel <= 1'b1;
		dacc <= 1'b1;
		rd_b <= 1'b0;
		wr_b <= 1'b0;
		mhold_b <= 1'b0;
		keep <= 1'b1;
		wt(3);
		chk("mode", 16'h0001, 16'(mode));
		chk("bus strobe", 16'h0000, 16'(strb));
		chk("addr pins", 16'h8BCD, {pout[2], pout[1]});
		chk("addr low", 16'h00EF, 16'(pout[0]));
		chk("ctrl pins", 16'hF00A, {poe_b[3], pout[3]});
		chk("hold and p42", 16'h0001, {14'h0000, hreq_b, poe_b[4][2]});
		chk("bus ready", 16'h0001, 16'(rdy_b));
		chk("wide bus", 16'h0001, 16'(b16));
		chk("wide read", 16'h1234, rdata);
		$display("expansion test done");
	endtask : expand_test
	// Microprocessor mode: phase clock pin and port 9 address or chip selects.
	task automatic micro_test();
		@(posedge clk);
		mpin <= 1'b1;
		msel <= 1'b0;
		phi <= 1'b1;
		p9fn <= 6'h1F;
		p9sel <= 3'h5;
		cs_b <= 5'h15;
		wt(3);
		chk("mode", 16'h0002, 16'(mode));
		chk("phase pin", 16'h0001, {14'h0000, poe_b[4][2], pout[4][2]});
		chk("p9 pins", 16'hE010, {poe_b[9], pout[9]});
		$display("microprocessor test done");
	endtask : micro_test
	// A second reset selects the 8-bit bus; port 11 stays a port and reads use port 10.
	task automatic byte_test();
		rst(1'b1, 1'b1);
		chk("byte bus", 16'h00FF, {7'h00, b16, poe_b[11]});
		chk("byte read", 16'h3400, rdata);
		$display("byte bus test done");
	endtask : byte_test
	initial begin
		rst(1'b0, 1'b0);
		single_test();
		alt_test();
		expand_test();
		micro_test();
		byte_test();
		wrap_up();
	end
endmodule : pin_function_mux_bench
`default_nettype wire
